// file: pkg/pmm_map.svh
// Constants of the port mirror mapper: sizes, encodings and reset values.
// Assumes inclusion by bare name from the package and the design files.
`ifndef PMM_MAP_SVH
`define PMM_MAP_SVH

// ============================================================
// Sizes
`define PMM_NPORTS       8
`define PMM_DATA_W       32
`define PMM_FIFO_DEPTH   16

// ============================================================
// Management operation encodings
`define PMM_OP_W         2
`define PMM_OP_ADD       2'h0
`define PMM_OP_REMOVE    2'h1
`define PMM_OP_SET_ERR   2'h2

// ============================================================
// Reset values
`define PMM_ERR_COPY_RST 1'b1

`endif

// file: pkg/pmm_pkg.sv
// Types shared by the port mirror mapper files.
// Assumes pmm_map.svh is on the include path.
`default_nettype none
`include "pmm_map.svh"

package pmm_pkg;

	// ============================================================
	// Management operations
	typedef enum logic [`PMM_OP_W-1:0] {
		PMM_ADD          = `PMM_OP_ADD,
		PMM_REMOVE_ENTRY = `PMM_OP_REMOVE,
		PMM_SET_ERR      = `PMM_OP_SET_ERR
	} pmm_op_type;

endpackage

`default_nettype wire

// file: pkg/pmm_stream_if.sv
// Valid/ready stream carrier between the mapper and its mirror FIFO.
// Assumes both ends share one clock.
`default_nettype none

interface pmm_stream_if #(
	parameter int W = 8
) ();
	logic         valid;
	logic         ready;
	logic [W-1:0] data;

	// ============================================================
	// Producer drives valid and data, consumer drives ready.
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

// file: logic/pmm_fifo.sv
// Synchronous FIFO with valid/ready on both sides, used for mirrored beats.
// Assumes one clock; ce low freezes all state.
`default_nettype none
`include "pmm_map.svh"

module pmm_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = `PMM_FIFO_DEPTH
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	pmm_stream_if.snk       push,
	pmm_stream_if.src       pop
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0]  mem_r [DEPTH];
	logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
	logic [AW:0]   cnt_r, cnt_nxt;
	logic          do_wr, do_rd;

	// ============================================================
	// Handshakes: full and empty come straight from the count.
	assign push.ready = (cnt_r != (AW+1)'(DEPTH));
	assign pop.valid  = (cnt_r != '0);
	assign pop.data   = mem_r[rd_r];
	assign do_wr      = ce & push.valid & push.ready;
	assign do_rd      = ce & pop.valid & pop.ready;

	// Pointer and count next values; wrap handles depths not a power of two.
	always_comb begin
		wr_nxt  = wr_r;
		rd_nxt  = rd_r;
		cnt_nxt = cnt_r;
		if (do_wr) begin
			wr_nxt = (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
		end
		if (do_rd) begin
			rd_nxt = (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
		end
		cnt_nxt = cnt_r + (AW+1)'(do_wr) - (AW+1)'(do_rd);
	end

	// Pointer registers.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_r  <= '0;
			rd_r  <= '0;
			cnt_r <= '0;
		end else begin
			wr_r  <= wr_nxt;
			rd_r  <= rd_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// Storage holds no reset; nothing is read before it is written.
	always_ff @(posedge clk) begin
		if (do_wr) begin
			mem_r[wr_r] <= push.data;
		end
	end
endmodule // pmm_fifo

`default_nettype wire

// file: logic/pmm_mapper.sv
// Port mirror mapper: forwards every ingress beat unchanged and copies the
// frames of mapped source ports, tagged with their destination, to a FIFO,
// except frames errored at sop on a source whose error copy is off.
// Assumes all inputs come from logic on clk; errored status rides on sop.
`default_nettype none
`include "pmm_map.svh"

module pmm_mapper #(
	parameter int NPORTS = `PMM_NPORTS,
	parameter int DW     = `PMM_DATA_W,
	parameter int DEPTH  = `PMM_FIFO_DEPTH,
	localparam int PW    = $clog2(NPORTS)
) (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              ce,
	input  wire logic              in_valid,
	output logic                   in_ready,
	input  wire logic [PW-1:0]     in_port,
	input  wire logic [DW-1:0]     in_data,
	input  wire logic              in_sop,
	input  wire logic              in_eop,
	input  wire logic              in_err,
	output logic                   fwd_valid,
	input  wire logic              fwd_ready,
	output logic [PW-1:0]          fwd_port,
	output logic [DW-1:0]          fwd_data,
	output logic                   fwd_sop,
	output logic                   fwd_eop,
	output logic                   fwd_err,
	output logic                   mir_valid,
	input  wire logic              mir_ready,
	output logic [PW-1:0]          mir_port,
	output logic [DW-1:0]          mir_data,
	output logic                   mir_sop,
	output logic                   mir_eop,
	output logic                   mir_err,
	input  wire logic              cfg_valid,
	input  wire pmm_pkg::pmm_op_type cfg_op,
	input  wire logic [PW-1:0]     cfg_src,
	input  wire logic [PW-1:0]     cfg_dst,
	input  wire logic              cfg_err_copy,
	input  wire logic              cfg_commit,
	output logic                   cfg_done,
	output logic                   cfg_reject,
	input  wire logic [PW-1:0]     rd_idx,
	output logic                   rd_en,
	output logic [PW-1:0]          rd_dst,
	output logic                   rd_err,
	output logic [NPORTS-1:0]      act_mask
);
	localparam int MW = PW + DW + 3;

	logic [NPORTS-1:0] stg_en_r, stg_en_nxt, stg_err_r, stg_err_nxt;
	logic [PW-1:0]     stg_dst_r [NPORTS];
	logic [PW-1:0]     stg_dst_nxt [NPORTS];
	logic [NPORTS-1:0] act_en_r, act_en_nxt, act_err_r, act_err_nxt;
	logic [PW-1:0]     act_dst_r [NPORTS];
	logic [PW-1:0]     act_dst_nxt [NPORTS];
	logic              done_nxt, reject_nxt, done_r, reject_r, dst_busy;
	logic [NPORTS-1:0] cp_r, cp_nxt;
	logic [PW-1:0]     cp_dst_r [NPORTS];
	logic [PW-1:0]     cp_dst_nxt [NPORTS];
	logic              accept, copy_now, fwd_free;
	logic [PW-1:0]     copy_dst;
	logic              fv_r, fv_nxt;
	logic [PW+DW+2:0]  fb_r, fb_nxt;
	logic              rd_en_r, rd_err_r;
	logic [PW-1:0]     rd_dst_r;

	pmm_stream_if #(.W(MW)) mq_in ();
	pmm_stream_if #(.W(MW)) mq_out ();

	// ============================================================
	// Staged table: management edits land here first.
	always_comb begin
		stg_en_nxt  = stg_en_r;
		stg_err_nxt = stg_err_r;
		stg_dst_nxt = stg_dst_r;
		done_nxt    = 1'b0;
		reject_nxt  = 1'b0;
		dst_busy    = 1'b0;
		for (int i = 0; i < NPORTS; i++) begin
			if (stg_en_r[i] && stg_dst_r[i] == cfg_dst && PW'(i) != cfg_src) begin
				dst_busy = 1'b1;
			end
		end
		if (cfg_valid) begin
			case (cfg_op)
				pmm_pkg::PMM_ADD: begin
					// A second destination or a second source is refused.
					if (stg_en_r[cfg_src] || dst_busy || cfg_src == cfg_dst) begin
						reject_nxt = 1'b1;
					end else begin
						stg_en_nxt[cfg_src]  = 1'b1;
						stg_dst_nxt[cfg_src] = cfg_dst;
						stg_err_nxt[cfg_src] = cfg_err_copy;
						done_nxt             = 1'b1;
					end
				end
				pmm_pkg::PMM_REMOVE_ENTRY: begin
					if (stg_en_r[cfg_src] && stg_dst_r[cfg_src] == cfg_dst) begin
						stg_en_nxt[cfg_src]  = 1'b0;
						stg_err_nxt[cfg_src] = `PMM_ERR_COPY_RST;
						done_nxt             = 1'b1;
					end else begin
						reject_nxt = 1'b1;
					end
				end
				pmm_pkg::PMM_SET_ERR: begin
					if (stg_en_r[cfg_src]) begin
						stg_err_nxt[cfg_src] = cfg_err_copy;
						done_nxt             = 1'b1;
					end else begin
						reject_nxt = 1'b1;
					end
				end
				default: begin
					reject_nxt = 1'b1;
				end
			endcase
		end
	end

	// Active table: commit copies the staged table, including an edit in the
	// same cycle, so several edits switch over in one step.
	always_comb begin
		act_en_nxt  = act_en_r;
		act_err_nxt = act_err_r;
		act_dst_nxt = act_dst_r;
		if (cfg_commit) begin
			act_en_nxt  = stg_en_nxt;
			act_err_nxt = stg_err_nxt;
			act_dst_nxt = stg_dst_nxt;
		end
	end

	// Both tables and the operation answers.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stg_en_r  <= '0;
			stg_err_r <= {NPORTS{`PMM_ERR_COPY_RST}};
			act_en_r  <= '0;
			act_err_r <= {NPORTS{`PMM_ERR_COPY_RST}};
			stg_dst_r <= '{default: '0};
			act_dst_r <= '{default: '0};
			done_r    <= 1'b0;
			reject_r  <= 1'b0;
		end else if (ce) begin
			stg_en_r  <= stg_en_nxt;
			stg_err_r <= stg_err_nxt;
			stg_dst_r <= stg_dst_nxt;
			act_en_r  <= act_en_nxt;
			act_err_r <= act_err_nxt;
			act_dst_r <= act_dst_nxt;
			done_r    <= done_nxt;
			reject_r  <= reject_nxt;
		end
	end

	// ============================================================
	// Ingress: one stall holds both paths, so forwarding never drops a beat
	// the mirror could not take, at the cost of a full FIFO pausing traffic.
	assign fwd_free = ~fv_r | fwd_ready;
	assign in_ready = fwd_free & mq_in.ready;
	assign accept   = ce & in_valid & in_ready;

	// The copy decision is frozen at sop, so a commit mid-frame never
	// splits a frame; beats of an unmapped frame start no copy.
	always_comb begin
		cp_nxt     = cp_r;
		cp_dst_nxt = cp_dst_r;
		copy_now   = cp_r[in_port];
		copy_dst   = cp_dst_r[in_port];
		if (in_sop) begin
			copy_now = act_en_r[in_port] & (act_err_r[in_port] | ~in_err);
			copy_dst = act_dst_r[in_port];
		end
		if (accept) begin
			cp_nxt[in_port]     = copy_now & ~in_eop;
			cp_dst_nxt[in_port] = copy_dst;
		end
	end

	// Per-source copy state.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cp_r     <= '0;
			cp_dst_r <= '{default: '0};
		end else if (ce) begin
			cp_r     <= cp_nxt;
			cp_dst_r <= cp_dst_nxt;
		end
	end

	assign mq_in.valid = ce & in_valid & in_ready & copy_now;
	assign mq_in.data  = {copy_dst, in_data, in_sop, in_eop, in_err};

	pmm_fifo #(.W(MW), .DEPTH(DEPTH)) u_mirror_q (
		.clk   (clk),
		.rst_n (rst_n),
		.ce    (ce),
		.push  (mq_in),
		.pop   (mq_out)
	);

	assign mq_out.ready = mir_ready;
	assign mir_valid    = mq_out.valid;
	assign {mir_port, mir_data, mir_sop, mir_eop, mir_err} = mq_out.data;

	// ============================================================
	// Forward register: every beat goes out unchanged whether mirrored or not.
	always_comb begin
		fv_nxt = fv_r;
		fb_nxt = fb_r;
		if (accept) begin
			fv_nxt = 1'b1;
			fb_nxt = {in_port, in_data, in_sop, in_eop, in_err};
		end else if (fwd_ready) begin
			fv_nxt = 1'b0;
		end
	end

	// Forward and readback registers.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fv_r     <= 1'b0;
			fb_r     <= '0;
			rd_en_r  <= 1'b0;
			rd_dst_r <= '0;
			rd_err_r <= `PMM_ERR_COPY_RST;
		end else if (ce) begin
			fv_r     <= fv_nxt;
			fb_r     <= fb_nxt;
			rd_en_r  <= act_en_r[rd_idx];
			rd_dst_r <= act_dst_r[rd_idx];
			rd_err_r <= act_err_r[rd_idx];
		end
	end

	assign fwd_valid = fv_r;
	assign {fwd_port, fwd_data, fwd_sop, fwd_eop, fwd_err} = fb_r;
	assign rd_en      = rd_en_r;
	assign rd_dst     = rd_dst_r;
	assign rd_err     = rd_err_r;
	assign act_mask   = act_en_r;
	assign cfg_done   = done_r;
	assign cfg_reject = reject_r;

	// ============================================================
	// Checks.
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	logic dup_dst;
	always_comb begin
		dup_dst = 1'b0;
		for (int i = 0; i < NPORTS; i++) begin
			for (int j = i + 1; j < NPORTS; j++) begin
				if (stg_en_r[i] && stg_en_r[j] && stg_dst_r[i] == stg_dst_r[j]) begin
					dup_dst = 1'b1;
				end
			end
		end
	end

	sequence s_sop_beat;
		accept && in_sop;
	endsequence
	sequence s_add_req;
		ce && cfg_valid && cfg_op == pmm_pkg::PMM_ADD;
	endsequence

	a_fwd_unchanged: assert property (accept |=> fwd_valid && fwd_data == $past(in_data))
		else $error("Forwarded beat differs from ingress beat.");
	a_mirror_copy: assert property (s_sop_beat and act_en_r[in_port] && act_err_r[in_port]
		|-> mq_in.valid && mq_in.data[MW-1 -: PW] == act_dst_r[in_port])
		else $error("Mapped frame start was not mirrored.");
	a_err_drop: assert property (s_sop_beat and in_err && !act_err_r[in_port] |-> !mq_in.valid)
		else $error("Errored frame reached the mirror with error copy off.");
	a_src_single: assert property (s_add_req and stg_en_r[cfg_src] |=> cfg_reject && !cfg_done)
		else $error("Second destination for a source was accepted.");
	a_dst_single: assert property (!dup_dst)
		else $error("Two sources share one destination.");
	a_reject_keeps: assert property (s_add_req and reject_nxt |=> $stable(stg_en_r)
		&& $stable(stg_err_r) && ($stable(act_en_r) || $past(cfg_commit)))
		else $error("Rejected add changed the active table.");
	a_commit_load: assert property (ce && cfg_commit |=> act_en_r == $past(stg_en_nxt))
		else $error("Commit did not load the staged table.");
	a_err_default: assert property (ce && cfg_valid && cfg_op == pmm_pkg::PMM_REMOVE_ENTRY
		&& done_nxt |=> stg_err_r[$past(cfg_src)])
		else $error("Error copy did not return to on after removal.");
	a_readback: assert property (ce |=> rd_dst == $past(act_dst_r[rd_idx])
		&& rd_en == $past(act_en_r[rd_idx]))
		else $error("Readback does not match the active table.");
endmodule // pmm_mapper

`default_nettype wire

// file: verification/pmm_probe.sv
// Monitoring probe model on the mirror destination port.
// Assumes the bench seeds $urandom and drives hold to stall the probe.
`default_nettype none

module pmm_probe (
	input  wire logic clk,
	input  wire logic hold,
	output var logic  mir_ready
);
	timeunit 1ns;
	timeprecision 1ps;

	// ============================================================
	// Ready handshake
	// A real analyser pauses at any beat, so ready wanders at random.
	// One process owns ready, so it has a single driver from time zero on.
	initial begin
		mir_ready = 1'b0;
		forever begin
			@(posedge clk);
			#1 mir_ready = !hold && ($urandom % 3 != 0);
		end
	end
endmodule // pmm_probe

`default_nettype wire

// file: verification/port_mirror_mapper_test.sv
// Self-checking bench of the port mirror mapper.
// Assumes the package, stream interface, FIFO and mapper are compiled first.
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
	$display("mismatch %s exp %h got %h", n, e, g); end end

module port_mirror_mapper_test;
	timeunit 1ns;
	timeprecision 1ps;
	typedef logic [37:0] pmm_beat_type;
	logic clk = 0, rst_n = 0, ce = 1, jit = 0, hold = 0, fwd_ready = 1;
	logic in_valid = 0, in_sop = 0, in_eop = 0, in_err = 0;
	logic cfg_valid = 0, cfg_err_copy = 1, cfg_commit = 0;
	logic [2:0] in_port = 0, cfg_src = 0, cfg_dst = 0, rd_idx = 0;
	logic [31:0] in_data = 0;
	pmm_pkg::pmm_op_type cfg_op = pmm_pkg::PMM_ADD;
	logic in_ready, fwd_valid, fwd_sop, fwd_eop, fwd_err, mir_valid, mir_ready;
	logic mir_sop, mir_eop, mir_err, cfg_done, cfg_reject, rd_en, rd_err;
	logic [2:0] fwd_port, mir_port, rd_dst, s_dst[8], a_dst[8];
	logic [31:0] fwd_data, mir_data;
	logic [7:0] act_mask, s_en = 0, a_en = 0, s_err = 8'hff, a_err = 8'hff, cp = 0;
	pmm_beat_type fq[$], mq[$], e;
	int bad_count = 0, checked = 0;

	pmm_mapper dut (.clk(clk), .rst_n(rst_n), .ce(ce), .in_valid(in_valid),
		.in_ready(in_ready), .in_port(in_port), .in_data(in_data), .in_sop(in_sop),
		.in_eop(in_eop), .in_err(in_err), .fwd_valid(fwd_valid), .fwd_ready(fwd_ready),
		.fwd_port(fwd_port), .fwd_data(fwd_data), .fwd_sop(fwd_sop), .fwd_eop(fwd_eop),
		.fwd_err(fwd_err), .mir_valid(mir_valid), .mir_ready(mir_ready),
		.mir_port(mir_port), .mir_data(mir_data), .mir_sop(mir_sop), .mir_eop(mir_eop),
		.mir_err(mir_err), .cfg_valid(cfg_valid), .cfg_op(cfg_op), .cfg_src(cfg_src),
		.cfg_dst(cfg_dst), .cfg_err_copy(cfg_err_copy), .cfg_commit(cfg_commit),
		.cfg_done(cfg_done), .cfg_reject(cfg_reject), .rd_idx(rd_idx), .rd_en(rd_en),
		.rd_dst(rd_dst), .rd_err(rd_err), .act_mask(act_mask));
	pmm_probe probe (.clk(clk), .hold(hold), .mir_ready(mir_ready));

	// ============================================================
	// Clock, random stalls and output checking
	always #2 clk = ~clk;
	// Forward stalls and clock-enable gaps come at random to shake the handshakes.
	always @(posedge clk) begin
		#1 fwd_ready = ($urandom % 4 != 0);
		ce = !jit || ($urandom % 8 != 0);
	end
	// Each delivered beat is matched against the oldest expectation.
	always @(posedge clk) if (rst_n && ce) begin
		if (fwd_valid && fwd_ready) begin
			e = fq.size() ? fq.pop_front() : 'x;
			`CHK("fwd", e, {fwd_port, fwd_data, fwd_sop, fwd_eop, fwd_err})
		end
		if (mir_valid && mir_ready) begin
			e = mq.size() ? mq.pop_front() : 'x;
			`CHK("mir", e, {mir_port, mir_data, mir_sop, mir_eop, mir_err})
		end
	end

	// ============================================================
	// Tasks
	task automatic tick();
		@(posedge clk);
		#1;
	endtask

	function automatic logic used(logic [2:0] d);
		used = 0;
		for (int j = 0; j < 8; j++) if (s_en[j] && s_dst[j] == d) used = 1;
	endfunction

	// Valid stays high so that ops can follow each other every cycle.
	task automatic op(pmm_pkg::pmm_op_type o, logic [2:0] s, logic [2:0] d, logic er);
		logic ok;
		ok = (o == pmm_pkg::PMM_ADD) ? (!s_en[s] && s != d && !used(d)) :
			(o == pmm_pkg::PMM_REMOVE_ENTRY) ? (s_en[s] && s_dst[s] == d) :
			(o == pmm_pkg::PMM_SET_ERR) ? s_en[s] : 1'b0;
		cfg_valid = 1;
		cfg_op = o;
		cfg_src = s;
		cfg_dst = d;
		cfg_err_copy = er;
		tick();
		`CHK("done", ok, cfg_done)
		`CHK("reject", !ok, cfg_reject)
		`CHK("act_mask", a_en, act_mask)
		if (ok && o == pmm_pkg::PMM_ADD) begin
			s_en[s] = 1;
			s_dst[s] = d;
			s_err[s] = er;
		end
		if (ok && o == pmm_pkg::PMM_REMOVE_ENTRY) begin
			s_en[s] = 0;
			s_err[s] = 1;
		end
		if (ok && o == pmm_pkg::PMM_SET_ERR) s_err[s] = er;
	endtask

	task automatic commit();
		cfg_valid = 0;
		cfg_commit = 1;
		tick();
		cfg_commit = 0;
		a_en = s_en;
		a_dst = s_dst;
		a_err = s_err;
		`CHK("act_mask", a_en, act_mask)
		for (int i = 0; i < 8; i++) begin
			rd_idx = i[2:0];
			tick();
			`CHK("rd_en", a_en[i], rd_en)
			`CHK("rd_err", a_err[i], rd_err)
			if (a_en[i]) `CHK("rd_dst", a_dst[i], rd_dst)
		end
	endtask

	// The copy decision is made on the start beat and kept to the frame's end.
	task automatic beat(logic [2:0] p, logic so, logic eo, logic er, output logic ok);
		int n;
		in_valid = 1;
		in_port = p;
		in_sop = so;
		in_eop = eo;
		in_err = er;
		in_data = $urandom;
		n = 0;
		#1;
		while (!(in_ready && ce) && n < 40) begin
			tick();
			#1;
			n++;
		end
		ok = in_ready && ce;
		if (ok) begin
			if (so) cp[p] = a_en[p] && (a_err[p] || !er);
			fq.push_back({p, in_data, so, eo, er});
			if (cp[p]) mq.push_back({a_dst[p], in_data, so, eo, er});
		end
		tick();
	endtask

	task automatic traffic(int nf);
		logic ok;
		int len;
		logic [2:0] p;
		jit = 1;
		for (int i = 0; i < nf; i++) begin
			p = 3'($urandom % 8);
			len = 1 + $urandom % 4;
			for (int k = 0; k < len; k++) begin
				beat(p, k == 0, k == len - 1, $urandom % 4 == 0, ok);
				// A beat refused for the whole wait is a lost beat, not a pause.
				`CHK("ingress", 1'b1, ok)
			end
		end
		in_valid = 0;
		for (int i = 0; i < 400 && (fq.size() || mq.size()); i++) tick();
		`CHK("left", 0, fq.size() + mq.size())
		jit = 0;
		tick();
	endtask

	task automatic finish_test();
		$display("compares %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ============================================================
	// Watchdog and main sequence
	initial begin
		#80000;
		bad_count++;
		finish_test();
	end

	initial begin
		int acc;
		logic ok;
		void'($urandom(53));
		acc = 0;
		repeat (6) @(posedge clk);
		#1 rst_n = 1;
		tick();
		commit();
		op(pmm_pkg::PMM_ADD, 3'h1, 3'h5, 1'b1);
		op(pmm_pkg::PMM_ADD, 3'h2, 3'h6, 1'b1);
		op(pmm_pkg::PMM_ADD, 3'h3, 3'h7, 1'b0);
		op(pmm_pkg::PMM_ADD, 3'h5, 3'h1, 1'b0);
		op(pmm_pkg::PMM_ADD, 3'h1, 3'h6, 1'b1);
		op(pmm_pkg::PMM_ADD, 3'h4, 3'h5, 1'b1);
		op(pmm_pkg::PMM_ADD, 3'h0, 3'h0, 1'b1);
		op(pmm_pkg::PMM_REMOVE_ENTRY, 3'h3, 3'h6, 1'b0);
		op(pmm_pkg::PMM_SET_ERR, 3'h4, 3'h0, 1'b0);
		op(pmm_pkg::pmm_op_type'(2'h3), 3'h6, 3'h0, 1'b0);
		commit();
		traffic(40);
		op(pmm_pkg::PMM_SET_ERR, 3'h1, 3'h0, 1'b0);
		op(pmm_pkg::PMM_REMOVE_ENTRY, 3'h2, 3'h6, 1'b0);
		op(pmm_pkg::PMM_ADD, 3'h6, 3'h2, 1'b1);
		commit();
		traffic(40);
		// With the probe stalled, the mirror buffer must refuse the seventeenth beat.
		hold = 1;
		for (int i = 0; i < 17; i++) begin
			beat(3'h1, i == 0, 1'b0, 1'b0, ok);
			acc += ok;
		end
		`CHK("accepted", 16, acc)
		hold = 0;
		traffic(10);
		for (int i = 0; i < 40; i++)
			op(pmm_pkg::pmm_op_type'($urandom % 4), 3'($urandom % 8), 3'($urandom % 8),
				1'($urandom % 2));
		commit();
		traffic(40);
		finish_test();
	end
endmodule // port_mirror_mapper_test

`default_nettype wire
